// [field_fifo_pkg.sv]
// Constants and types shared by the field FIFO design files.
// Assumes one system clock domain; all port pins are sampled by it.
`default_nettype none

package field_fifo_pkg;

  // ************************************************************
  // Widths and depths
  // ************************************************************
  localparam int WORD_W = 12;
  localparam int ADDR_W = 18;
  localparam int DEPTH = 262144;
  localparam int SLOT_W = 8;
  localparam int SLOTS = 256;

  // ************************************************************
  // Synchroniser group layout
  // ************************************************************
  localparam int WSYNC_W = 16;
  localparam int W_CLK_BIT = 15;
  localparam int W_GATE_BIT = 14;
  localparam int W_MASK_BIT = 13;
  localparam int W_CLR_BIT = 12;
  localparam int RSYNC_W = 4;
  localparam int R_CLK_BIT = 3;
  localparam int R_GATE_BIT = 2;
  localparam int R_CLR_BIT = 1;
  localparam int R_OE_BIT = 0;

  // ************************************************************
  // Reset and step values
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h00001;
  localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
  localparam logic [SLOT_W-1:0] SLOT_RESET = 8'h00;
  localparam logic [SLOT_W-1:0] SLOT_ONE = 8'h01;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 8'hFF;
  localparam logic [SLOTS-1:0] PEND_RESET = 256'h0;

  // ************************************************************
  // Staging flush machine
  // ************************************************************
  typedef enum logic [1:0] {
    FLUSH_IDLE = 2'b01,
    FLUSH_RUN = 2'b10
  } flush_state_t;

endpackage : field_fifo_pkg

`default_nettype wire

// [sync_stage.sv]
// Two flip-flop synchroniser for a group of pin levels.
// Assumes each bit is a level from outside the system clock domain.
`timescale 1ns/1ps
`default_nettype none

module sync_stage #(
  parameter int W = 1
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ************************************************************
  // Stages
  // ************************************************************
  logic [W-1:0] meta;

  // First stage feeds only the second one
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : sync_stage

`default_nettype wire

// [dual_clock_field_fifo.sv]
// Serial field memory acting as a 12-bit word delay line.
// Assumes port clocks run well below the system clock rate.
//
// Operation
// - Separate write and read ports, own clocks
// - Closing clear moves staged words into array
// - Write timing lags read timing one clock
// - First clear edge zeroes write address
// - Active write edge captures word, advances pointer
// - Gate low holds write pointer, ignores data
// - Mask low skips storing, pointer still advances
// - First clear edge zeroes read address
// - Active read edge shifts word, advances pointer
// - Fetch gate low holds read pointer
// - Drive gate enables outputs, pointer unaffected
// - Output word keeps written polarity
// - Storage arbitrated internally, clocks may stop
// - 256-word line buffer, no first-word latency
// - Spacing under 256 words still returns old field
`timescale 1ns/1ps
`default_nettype none

module dual_clock_field_fifo
  import field_fifo_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic write_clock_in,
  input wire logic write_clock_gate_in,
  input wire logic store_mask_in,
  input wire logic write_pointer_clear_in,
  input wire logic [WORD_W-1:0] input_word_in,
  input wire logic read_clock_in,
  input wire logic fetch_gate_in,
  input wire logic read_pointer_clear_in,
  input wire logic output_drive_gate_in,
  output logic [WORD_W-1:0] output_word_out,
  output logic output_word_oe_out
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction : rise

  function automatic logic [SLOT_W-1:0] slot_of(input logic [ADDR_W-1:0] a);
    slot_of = a[SLOT_W-1:0];
  endfunction : slot_of

  // ************************************************************
  // Pin sampling
  // ************************************************************
  logic [WSYNC_W-1:0] w_s;
  logic [RSYNC_W-1:0] r_s;

  // Each port has its own sampled group
  sync_stage #(.W(WSYNC_W)) u_wsync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in({write_clock_in, write_clock_gate_in, store_mask_in,
               write_pointer_clear_in, input_word_in}),
    .sync_out(w_s)
  );

  sync_stage #(.W(RSYNC_W)) u_rsync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in({read_clock_in, fetch_gate_in, read_pointer_clear_in,
               output_drive_gate_in}),
    .sync_out(r_s)
  );

  // ************************************************************
  // Storage
  // ************************************************************
  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] line_data [SLOTS];
  logic [ADDR_W-1:0] line_addr [SLOTS];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [WORD_W-1:0] mem_wd;
  logic line_we;

  // ************************************************************
  // Write port state
  // ************************************************************
  logic wclk_prev, next_wclk_prev;
  logic wclr_last, next_wclr_last;
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic stage_valid, next_stage_valid;
  logic [ADDR_W-1:0] stage_addr, next_stage_addr;
  logic [WORD_W-1:0] stage_data, next_stage_data;
  logic [SLOTS-1:0] line_pend, next_line_pend;
  flush_state_t flush_state, next_flush_state;
  logic [SLOT_W-1:0] flush_idx, next_flush_idx;
  logic wr_edge, clear_ev, w_active, push;
  logic [SLOT_W-1:0] push_slot;

  assign wr_edge = rise(w_s[W_CLK_BIT], wclk_prev);
  // Clear level is judged at port edges only, so a held clear acts once
  assign clear_ev = wr_edge & w_s[W_CLR_BIT] & ~wclr_last;
  // Gate and mask are ignored in the clear cycle
  assign w_active = wr_edge & w_s[W_GATE_BIT] & ~clear_ev;
  // Staged word enters the line buffer at the next active or clear edge
  assign push = (w_active | clear_ev) & stage_valid;
  assign push_slot = slot_of(stage_addr);

  always_comb
  begin
    next_wclk_prev = w_s[W_CLK_BIT];
    next_wclr_last = wclr_last;
    next_wr_addr = wr_addr;
    next_stage_valid = stage_valid;
    next_stage_addr = stage_addr;
    next_stage_data = stage_data;
    next_line_pend = line_pend;
    next_flush_state = flush_state;
    next_flush_idx = flush_idx;
    mem_we = 1'b0;
    mem_wa = stage_addr;
    mem_wd = stage_data;
    line_we = 1'b0;
    if (wr_edge)
    begin
      next_wclr_last = w_s[W_CLR_BIT];
    end
    if (clear_ev)
    begin
      next_wr_addr = ADDR_RESET;
      next_stage_valid = 1'b0;
      next_flush_state = FLUSH_RUN;
      next_flush_idx = SLOT_RESET;
    end
    else if (w_active)
    begin
      next_wr_addr = wr_addr + ADDR_ONE;
      // Masked words are never staged, the old contents stay
      next_stage_valid = w_s[W_MASK_BIT];
      next_stage_addr = wr_addr;
      next_stage_data = w_s[WORD_W-1:0];
    end
    // Gate low leaves pointer and stage alone
    if (push)
    begin
      // Slot is evicted into the array when reused or by the flush after a clear, so a reader
      // trailing by under a line still sees the old field
      if (line_pend[push_slot])
      begin
        mem_we = 1'b1;
        mem_wa = line_addr[push_slot];
        mem_wd = line_data[push_slot];
      end
      line_we = 1'b1;
      next_line_pend[push_slot] = 1'b1;
    end
    else if (!clear_ev)
    begin
      // Flush takes the array only in cycles the port leaves free
      unique case (flush_state)
        FLUSH_IDLE:
        begin
        end
        FLUSH_RUN:
        begin
          if (line_pend[flush_idx])
          begin
            mem_we = 1'b1;
            mem_wa = line_addr[flush_idx];
            mem_wd = line_data[flush_idx];
            next_line_pend[flush_idx] = 1'b0;
          end
          next_flush_idx = flush_idx + SLOT_ONE;
          if (flush_idx == SLOT_LAST)
          begin
            next_flush_state = FLUSH_IDLE;
          end
        end
        default:
        begin
          next_flush_state = FLUSH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      wclk_prev <= 1'b0;
      wclr_last <= 1'b0;
      wr_addr <= ADDR_RESET;
      stage_valid <= 1'b0;
      stage_addr <= ADDR_RESET;
      stage_data <= WORD_RESET;
      line_pend <= PEND_RESET;
      flush_state <= FLUSH_IDLE;
      flush_idx <= SLOT_RESET;
    end
    else
    begin
      wclk_prev <= next_wclk_prev;
      wclr_last <= next_wclr_last;
      wr_addr <= next_wr_addr;
      stage_valid <= next_stage_valid;
      stage_addr <= next_stage_addr;
      stage_data <= next_stage_data;
      line_pend <= next_line_pend;
      flush_state <= next_flush_state;
      flush_idx <= next_flush_idx;
    end
  end

  // Storage holds its contents with port clocks stopped
  always_ff @(posedge sys_clk_in)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
    if (line_we)
    begin
      line_addr[push_slot] <= stage_addr;
      line_data[push_slot] <= stage_data;
    end
  end

  // ************************************************************
  // Read port state
  // ************************************************************
  logic rclk_prev, next_rclk_prev;
  logic rclr_last, next_rclr_last;
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic [WORD_W-1:0] next_out_word;
  logic next_out_oe;
  logic rd_edge, rclr_ev, r_active;
  logic [WORD_W-1:0] rd_word;

  assign rd_edge = rise(r_s[R_CLK_BIT], rclk_prev);
  assign rclr_ev = rd_edge & r_s[R_CLR_BIT] & ~rclr_last;
  assign r_active = rd_edge & r_s[R_GATE_BIT] & ~rclr_ev;
  assign rd_word = mem[rd_addr];

  always_comb
  begin
    next_rclk_prev = r_s[R_CLK_BIT];
    next_rclr_last = rclr_last;
    next_rd_addr = rd_addr;
    next_out_word = output_word_out;
    next_out_oe = output_word_oe_out;
    if (rd_edge)
    begin
      next_rclr_last = r_s[R_CLR_BIT];
      // Drive gate is sampled at port edges and never stops the pointer
      next_out_oe = r_s[R_OE_BIT];
    end
    if (rclr_ev)
    begin
      next_rd_addr = ADDR_RESET;
    end
    else if (r_active)
    begin
      // Address zero is already selected, so no extra edge is needed
      next_rd_addr = rd_addr + ADDR_ONE;
      next_out_word = rd_word;
    end
    // Fetch gate low holds pointer and word
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      rclk_prev <= 1'b0;
      rclr_last <= 1'b0;
      rd_addr <= ADDR_RESET;
      output_word_out <= WORD_RESET;
      output_word_oe_out <= 1'b0;
    end
    else
    begin
      rclk_prev <= next_rclk_prev;
      rclr_last <= next_rclr_last;
      rd_addr <= next_rd_addr;
      output_word_out <= next_out_word;
      output_word_oe_out <= next_out_oe;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking chk_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  wptr_clear_a: assert property (clear_ev |=> wr_addr == ADDR_RESET)
    else $error("write clear did not zero the pointer");
  wptr_step_a: assert property (w_active |=> wr_addr == $past(wr_addr) + ADDR_ONE)
    else $error("active write edge did not advance the pointer");
  wptr_hold_a: assert property (!w_active && !clear_ev |=> $stable(wr_addr))
    else $error("write pointer moved without an active edge");
  mask_skip_a: assert property (w_active && !w_s[W_MASK_BIT] |=> !stage_valid)
    else $error("masked word was staged");
  stage_word_a: assert property (w_active && w_s[W_MASK_BIT]
    |=> stage_valid && stage_data == $past(w_s[WORD_W-1:0]) ##1 !line_we [*3])
    else $error("staged word wrong or pushed early");
  flush_done_a: assert property (clear_ev |-> ##[1:600] flush_state == FLUSH_IDLE)
    else $error("staging flush did not finish");
  rptr_clear_a: assert property (rclr_ev |=> rd_addr == ADDR_RESET)
    else $error("read clear did not zero the pointer");
  rptr_step_a: assert property (r_active |=> rd_addr == $past(rd_addr) + ADDR_ONE)
    else $error("active read edge did not advance the pointer");
  rptr_hold_a: assert property (!r_active && !rclr_ev |=> $stable(rd_addr))
    else $error("read pointer moved without an active edge");
  out_word_a: assert property (r_active |=> output_word_out == $past(rd_word))
    else $error("output word differs from stored word");
  oe_follow_a: assert property (rd_edge |=> output_word_oe_out == $past(r_s[R_OE_BIT]))
    else $error("output enable does not follow drive gate");

endmodule : dual_clock_field_fifo

`default_nettype wire

// [field_partner.sv]
// Partner model: video logic driving the write and read ports.
// Assumes a 1 ns time unit; port clocks stand still between task calls.
`timescale 1ns/1ps
`default_nettype none

module field_partner
  import field_fifo_pkg::*;
(
  output logic write_clock_out,
  output logic write_clock_gate_out,
  output logic store_mask_out,
  output logic write_pointer_clear_out,
  output logic [WORD_W-1:0] input_word_out,
  output logic read_clock_out,
  output logic fetch_gate_out,
  output logic read_pointer_clear_out,
  output logic output_drive_gate_out
);
  // ********************
  // Port cycles of 64 ns
  // ********************
  initial
  begin
    {write_clock_out, write_clock_gate_out, store_mask_out, write_pointer_clear_out} = 4'h0;
    input_word_out = WORD_RESET;
    {read_clock_out, fetch_gate_out, read_pointer_clear_out, output_drive_gate_out} = 4'h0;
  end

  task automatic write_cycle(input logic gate, input logic mask, input logic clr,
    input logic [WORD_W-1:0] word);
    // Non-blocking drives keep pin changes off the sampling edge of the system clock
    write_clock_gate_out <= gate;
    store_mask_out <= mask;
    write_pointer_clear_out <= clr;
    input_word_out <= word;
    #32 write_clock_out <= 1'b1;
    // Hold time over: the data lines stop showing the word
    #10 input_word_out <= ~word;
    #22 write_clock_out <= 1'b0;
  endtask : write_cycle

  task automatic read_cycle(input logic fetch, input logic drive, input logic clr);
    fetch_gate_out <= fetch;
    output_drive_gate_out <= drive;
    read_pointer_clear_out <= clr;
    #32 read_clock_out <= 1'b1;
    #32 read_clock_out <= 1'b0;
  endtask : read_cycle

  task automatic init_sequence();
    #100000;
    repeat (80) write_cycle(1'b1, 1'b1, 1'b0, WORD_RESET);
    write_cycle(1'b0, 1'b0, 1'b1, WORD_RESET);
    repeat (2) write_cycle(1'b0, 1'b0, 1'b0, WORD_RESET);
    // Dummy reads trail the flushed dummy words, so none fetches an unwritten location
    repeat (80) read_cycle(1'b1, 1'b0, 1'b0);
    read_cycle(1'b0, 1'b0, 1'b1);
    repeat (2) read_cycle(1'b0, 1'b0, 1'b0);
  endtask : init_sequence
endmodule : field_partner

`default_nettype wire

// [dual_clock_field_fifo_tb.sv]
// Self-checking bench for the field memory, driven through the partner.
// Assumes the design samples every port pin with its 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module dual_clock_field_fifo_tb
  import field_fifo_pkg::*;
;
  localparam int N = 120;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wclk, wgate, wmask, wclr, rclk, rgate, rclr, rdrive, output_word_oe_out;
  logic [WORD_W-1:0] input_word, output_word_out;
  logic [WORD_W-1:0] mem [0:N-1];
  logic [WORD_W-1:0] fresh [0:N-1];
  logic [31:0] rng_state = 32'h00007792;
  int errors = 0;
  int checks_done = 0;
  int cycle_count = 0;

  always #2.5 sys_clk_in = ~sys_clk_in;

  field_partner field_partner_inst (
    .write_clock_out(wclk),
    .write_clock_gate_out(wgate),
    .store_mask_out(wmask),
    .write_pointer_clear_out(wclr),
    .input_word_out(input_word),
    .read_clock_out(rclk),
    .fetch_gate_out(rgate),
    .read_pointer_clear_out(rclr),
    .output_drive_gate_out(rdrive)
  );

  dual_clock_field_fifo dual_clock_field_fifo_inst (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .write_clock_in(wclk),
    .write_clock_gate_in(wgate),
    .store_mask_in(wmask),
    .write_pointer_clear_in(wclr),
    .input_word_in(input_word),
    .read_clock_in(rclk),
    .fetch_gate_in(rgate),
    .read_pointer_clear_in(rclr),
    .output_drive_gate_in(rdrive),
    .output_word_out(output_word_out),
    .output_word_oe_out(output_word_oe_out)
  );

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [31:0] roll();
    rng_state = xorshift(rng_state);
    return rng_state;
  endfunction : roll

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // Clear, N stored or masked words with idle gaps, closing clear
  task automatic write_field(input logic masked);
    logic [31:0] r;
    int i;
    r = roll();
    field_partner_inst.write_cycle(1'b1, 1'b1, 1'b1, r[11:0]);
    i = 0;
    while (i < N)
    begin
      r = roll();
      if (r[19:16] == 4'h0)
        field_partner_inst.write_cycle(1'b0, 1'b1, 1'b0, r[11:0]);
      else
      begin
        field_partner_inst.write_cycle(1'b1, r[20] | ~masked, 1'b0, r[11:0]);
        if (r[20] | ~masked)
          fresh[i] = r[11:0];
        i++;
      end
    end
    field_partner_inst.write_cycle(1'b1, 1'b1, 1'b1, ~r[11:0]);
    repeat (2) field_partner_inst.write_cycle(1'b0, 1'b0, 1'b0, r[11:0]);
  endtask : write_field

  // Clear, then n words with random fetch and drive gates
  task automatic read_field(input int n);
    logic [31:0] r;
    logic [WORD_W-1:0] exp;
    int i;
    field_partner_inst.read_cycle(1'b1, 1'b1, 1'b1);
    i = 0;
    while (i < n)
    begin
      r = roll();
      field_partner_inst.read_cycle(r[2:0] != 3'h0, r[3], 1'b0);
      if (r[2:0] != 3'h0)
      begin
        exp = mem[i];
        i++;
      end
      if (i > 0)
        check(output_word_out, exp);
      check(output_word_oe_out, r[3]);
    end
  endtask : read_field

  // ********************
  // Sequence
  // ********************
  always @(posedge sys_clk_in)
  begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 80000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    check(output_word_oe_out, 1'b0);
    check(output_word_out, WORD_RESET);
    field_partner_inst.init_sequence();
    write_field(1'b0);
    mem = fresh;
    // Spacing cycles keep the fetch gate low, so no unwritten word reaches the output
    repeat (600) field_partner_inst.read_cycle(1'b0, 1'b0, 1'b0);
    read_field(N);
    // Reader clears shortly after the writer, so it must see the field before
    fork
      write_field(1'b1);
      begin
        #650;
        read_field(80);
      end
    join
    mem = fresh;
    repeat (600) field_partner_inst.read_cycle(1'b0, 1'b0, 1'b0);
    read_field(N);
    summarize();
  end
endmodule : dual_clock_field_fifo_tb

`default_nettype wire
